// ### hdl/chg_seq_pkg.sv
// Purpose: constants for the charger power-up sequencer
// Assumes: aclk at 10 MHz; all times converted to cycles here
// Notes:   long counts are also top-level parameters so a bench can shorten them
// Summary of operation
// - strict order regulator, qualify, detect, limit, converter
// - regulator on after present, margin, 220 ms
// - any condition false keeps high impedance state
// - qualify: below overvoltage, above minimum, test load
// - pass sets input good flag, interrupt pulse
// - failed qualification retries every 2 seconds
// - each bad adapter check lasts 30 ms
// - input overvoltage drops high side switch fast
// - termination and recharge deglitched 250 ms
// - system over-current opens battery switch after 100 us
// - battery overvoltage disables charge after 1 us
// - safety timer 10 hours when selected
// - top-off 30 minutes for code binary 10
// - wake pin low 0.9-1.3 s exits ship mode
// - wake pin low 8-12 s resets battery switch
// - full reset holds switch off 250-400 ms
// - ship mode entered 10-15 s after request
// - 500 kHz with regulator, 30 kHz without
// - power-on resets registers, enables comparators, interface
// - battery only: switch on, regulator off
// - overload opens switch, sets disable flag, held
// - after detection: interrupt, limit, power good, status
package chg_seq_pkg;
   localparam longint CLK_HZ          = 10000000;
   localparam longint T_BIAS_DLY_MS   = 220;
   localparam longint T_BADSRC_MS     = 30;
   localparam longint T_RETRY_S       = 2;
   localparam longint T_TERM_MS       = 250;
   localparam longint T_SYSOVLD_US    = 100;
   localparam longint T_BATOVP_US     = 1;
   localparam longint T_SAFETY_H      = 10;
   localparam longint T_TOPOFF_MIN    = 30;
   localparam longint T_SHIP_EXIT_MS  = 1000;
   localparam longint T_WAKE_RST_S    = 10;
   localparam longint T_BATRST_MS     = 300;
   localparam longint T_SM_DLY_S      = 12;
   localparam longint T_WDT_S         = 40;
   localparam longint T_DETECT_US     = 10;
   localparam longint F_DIG_HZ        = 500000;
   localparam longint F_LPDIG_HZ      = 30000;
   localparam int     CNT_W           = 40;
   localparam longint C_BIAS_DLY   = T_BIAS_DLY_MS * CLK_HZ / 1000;
   localparam longint C_BADSRC     = T_BADSRC_MS * CLK_HZ / 1000;
   localparam longint C_RETRY      = T_RETRY_S * CLK_HZ;
   localparam longint C_TERM       = T_TERM_MS * CLK_HZ / 1000;
   localparam longint C_SYSOVLD    = T_SYSOVLD_US * CLK_HZ / 1000000;
   localparam longint C_BATOVP     = T_BATOVP_US * CLK_HZ / 1000000;
   localparam longint C_SAFETY     = T_SAFETY_H * 3600 * CLK_HZ;
   localparam longint C_TOPOFF     = T_TOPOFF_MIN * 60 * CLK_HZ;
   localparam longint C_SHIP_EXIT  = T_SHIP_EXIT_MS * CLK_HZ / 1000;
   localparam longint C_WAKE_RST   = T_WAKE_RST_S * CLK_HZ;
   localparam longint C_BATRST     = T_BATRST_MS * CLK_HZ / 1000;
   localparam longint C_SM_DLY     = T_SM_DLY_S * CLK_HZ;
   localparam longint C_WDT        = T_WDT_S * CLK_HZ;
   localparam longint C_DETECT     = T_DETECT_US * CLK_HZ / 1000000;
   localparam longint C_DIV_FAST   = CLK_HZ / (2 * F_DIG_HZ);
   localparam longint C_DIV_SLOW   = CLK_HZ / (2 * F_LPDIG_HZ);
   // register map
   localparam logic [7:0] A_CTRL    = 8'h00;
   localparam logic [7:0] A_STATUS  = 8'h04;
   localparam logic [7:0] A_ILIM    = 8'h08;
   localparam logic [7:0] A_VLIM    = 8'h0C;
   // control bits
   localparam int B_HIGH_IMP = 0;
   localparam int B_CHG_EN   = 1;
   localparam int B_SAFE_SEL = 2;
   localparam int B_TOP_LO   = 3;
   localparam int B_TOP_HI   = 4;
   localparam int B_WD_KICK  = 5;
   localparam int B_SHIP_REQ = 6;
   localparam int B_SYS_RST  = 7;
   localparam int B_WD_EN    = 8;
   localparam logic [31:0] CTRL_RST = 32'h0000_0116;
   localparam logic [7:0]  ILIM_USB = 8'h05;
   localparam logic [7:0]  ILIM_ADP = 8'h18;
   localparam logic [7:0]  VLIM_RST = 8'h2D;
   localparam logic [2:0]  BUS_NONE = 3'h0;
   localparam logic [2:0]  BUS_USB  = 3'h1;
   localparam logic [2:0]  BUS_ADP  = 3'h3;
   localparam logic [1:0]  TOP_30M  = 2'h2;
   typedef enum {S_OFF, S_WAIT, S_QUAL, S_RETRY, S_DETECT, S_VLIM, S_RUN} pwr_state_t;
   typedef enum {Q_IDLE, Q_LOW, Q_DONE} wake_state_t;
endpackage

// ### hdl/charger_power_up_sequencer.sv
// Purpose: power-up ordering, protection deglitch, timers, ship mode, watchdog
// Assumes: comparator inputs are asynchronous; one AXI4-Lite slave for software
// Notes:   digital clock output, a toggling square wave, models the 500 kHz / 30 kHz selection
`timescale 1ns/100ps
`default_nettype none
module charger_power_up_sequencer
   import chg_seq_pkg::*;
#(
   parameter longint P_BIAS_DLY  = C_BIAS_DLY,
   parameter longint P_BADSRC    = C_BADSRC,
   parameter longint P_RETRY     = C_RETRY,
   parameter longint P_TERM      = C_TERM,
   parameter longint P_SAFETY    = C_SAFETY,
   parameter longint P_TOPOFF    = C_TOPOFF,
   parameter longint P_SHIP_EXIT = C_SHIP_EXIT,
   parameter longint P_WAKE_RST  = C_WAKE_RST,
   parameter longint P_BATRST    = C_BATRST,
   parameter longint P_SM_DLY    = C_SM_DLY,
   parameter longint P_WDT       = C_WDT,
   parameter longint P_DIV_SLOW  = C_DIV_SLOW
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        input_present,
   input  wire logic        input_above_bat,
   input  wire logic        boost_mode,
   input  wire logic        bus_below_bat,
   input  wire logic        input_overvoltage,
   input  wire logic        bus_above_min,
   input  wire logic        bat_above_depletion,
   input  wire logic        port_select,
   input  wire logic        term_cond,
   input  wire logic        rechg_cond,
   input  wire logic        sys_overcurrent,
   input  wire logic        bat_overvoltage,
   input  wire logic        bat_overload,
   input  wire logic        ship_mode_wake_pin_n,
   output logic             bias_regulator_en,
   output logic             high_impedance_state,
   output logic             test_load_en,
   output logic             converter_en,
   output logic             high_side_switch_en,
   output logic             battery_switch,
   output logic             charge_en,
   output logic             host_int_n,
   output logic             dig_clk_tick,
   output logic             safety_expired,
   output logic             charge_done
);
   localparam int NSYNC = 14;
   // ------------------------------------------------------------
   // input synchronisers: three flops, change taken on 2nd==3rd
   // ------------------------------------------------------------
   logic [NSYNC-1:0] raw, s1_q, s2_q, s3_q, in_q;
   assign raw = {input_present, input_above_bat, boost_mode, bus_below_bat,
                 input_overvoltage, bus_above_min, bat_above_depletion, port_select,
                 term_cond, rechg_cond, sys_overcurrent, bat_overvoltage,
                 bat_overload, ship_mode_wake_pin_n};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_q <= 14'h0001;
         s2_q <= 14'h0001;
         s3_q <= 14'h0001;
         in_q <= 14'h0001;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int i = 0; i < NSYNC; i++)
            if (s2_q[i] == s3_q[i]) in_q[i] <= s3_q[i];
      end
   end
   logic vpres, vabove, boost, bbelow, vov, bmin, bdpl, psel, term, rechg;
   logic sysoc, batov, ovld, wake_n;
   assign {vpres, vabove, boost, bbelow, vov, bmin, bdpl, psel, term, rechg,
           sysoc, batov, ovld, wake_n} = in_q;

   // ------------------------------------------------------------
   // register file and AXI4-Lite slave
   // ------------------------------------------------------------
   logic [31:0] ctrl_q;
   logic [7:0]  ilim_q, vlim_q;
   logic [2:0]  bus_stat_q;
   logic        input_good_flag_q, power_good_bit_q, battery_switch_disable_flag_q;
   logic        wd_fault_q, term_q, rechg_q, batov_q, sysoc_q;
   logic        aw_q, w_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        wr_go, wd_kick, ship_req, sys_rst_req, ilim_wr;
   assign s_axi_awready = !aw_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_q && !s_axi_bvalid;
   assign wr_go = aw_q && w_q && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign s_axi_bresp = (awaddr_q <= A_VLIM && awaddr_q[1:0] == 2'h0) ? 2'h0 : 2'h2;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         s_axi_bvalid <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   // self-clearing command bits: kick, ship request, full reset
   assign wd_kick     = wr_go && awaddr_q == A_CTRL && wstrb_q[0] && wdata_q[B_WD_KICK];
   assign ship_req    = wr_go && awaddr_q == A_CTRL && wstrb_q[0] && wdata_q[B_SHIP_REQ];
   assign sys_rst_req = wr_go && awaddr_q == A_CTRL && wstrb_q[0] && wdata_q[B_SYS_RST];
   assign ilim_wr     = wr_go && awaddr_q == A_ILIM && wstrb_q[0];
   always_ff @(posedge aclk) begin
      if (!aresetn || wd_fault_q) begin
         ctrl_q <= CTRL_RST;
         vlim_q <= VLIM_RST;
      end else if (wr_go) begin
         for (int b = 0; b < 4; b++)
            if (awaddr_q == A_CTRL && wstrb_q[b]) ctrl_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
         if (awaddr_q == A_VLIM && wstrb_q[0]) vlim_q <= wdata_q[7:0];
      end
   end
   logic [31:0] status_w;
   assign status_w = {16'h0, 3'h0, sysoc_q, batov_q, rechg_q, term_q, wd_fault_q,
                      battery_switch_disable_flag_q, power_good_bit_q,
                      input_good_flag_q, bus_stat_q, 2'h0};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'h0;
         case (s_axi_araddr)
            A_CTRL:   s_axi_rdata <= {ctrl_q[31:8], ctrl_q[7:5] & 3'h0, ctrl_q[4:0]};
            A_STATUS: s_axi_rdata <= status_w;
            A_ILIM:   s_axi_rdata <= {24'h0, ilim_q};
            A_VLIM:   s_axi_rdata <= {24'h0, vlim_q};
            default: begin
               s_axi_rdata <= '0;
               s_axi_rresp <= 2'h2;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // power-up sequence from input source
   // ------------------------------------------------------------
   pwr_state_t st_q;
   logic [CNT_W-1:0] seq_cnt_q;
   logic bias_ok, int_pulse;
   // margin test flips with direction of power flow
   assign bias_ok = vpres && (boost ? bbelow : vabove) && !ctrl_q[B_HIGH_IMP];
   assign int_pulse = (st_q == S_QUAL && seq_cnt_q == CNT_W'(P_BADSRC - 1) && !vov && bmin)
                    || (st_q == S_DETECT && seq_cnt_q == CNT_W'(C_DETECT - 1));
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= S_OFF;
         seq_cnt_q <= '0;
         input_good_flag_q <= 1'b0;
         power_good_bit_q <= 1'b0;
         bus_stat_q <= BUS_NONE;
         host_int_n <= 1'b1;
      end else begin
         host_int_n <= !int_pulse;
         seq_cnt_q <= seq_cnt_q + 1'b1;
         if (!bias_ok) begin
            st_q <= S_OFF;
            seq_cnt_q <= '0;
            input_good_flag_q <= 1'b0;
            power_good_bit_q <= 1'b0;
            bus_stat_q <= BUS_NONE;
         end else begin
            case (st_q)
               S_OFF: begin
                  st_q <= S_WAIT;
                  seq_cnt_q <= '0;
               end
               S_WAIT: if (seq_cnt_q == CNT_W'(P_BIAS_DLY - 1)) begin
                  st_q <= S_QUAL;
                  seq_cnt_q <= '0;
               end
               S_QUAL: if (seq_cnt_q == CNT_W'(P_BADSRC - 1)) begin
                  seq_cnt_q <= '0;
                  if (!vov && bmin) begin
                     input_good_flag_q <= 1'b1;
                     st_q <= S_DETECT;
                  end else begin
                     st_q <= S_RETRY;
                  end
               end
               S_RETRY: if (seq_cnt_q == CNT_W'(P_RETRY - P_BADSRC - 1)) begin
                  st_q <= S_QUAL;
                  seq_cnt_q <= '0;
               end
               S_DETECT: if (seq_cnt_q == CNT_W'(C_DETECT - 1)) begin
                  power_good_bit_q <= 1'b1;
                  bus_stat_q <= psel ? BUS_USB : BUS_ADP;
                  st_q <= S_VLIM;
               end
               S_VLIM: st_q <= S_RUN;
               S_RUN: seq_cnt_q <= '0;
               default: st_q <= S_OFF;
            endcase
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn || wd_fault_q) ilim_q <= ILIM_USB;
      else if (ilim_wr) ilim_q <= wdata_q[7:0];
      else if (st_q == S_DETECT && seq_cnt_q == CNT_W'(C_DETECT - 1))
         ilim_q <= psel ? ILIM_USB : ILIM_ADP;
   end
   assign bias_regulator_en = st_q != S_OFF && st_q != S_WAIT;
   assign high_impedance_state = !bias_regulator_en;
   assign test_load_en = st_q == S_QUAL;
   assign converter_en = st_q == S_RUN;
   // raw pin bypasses the synchroniser: 200 ns is two clocks
   assign high_side_switch_en = converter_en && !input_overvoltage;

   // ------------------------------------------------------------
   // deglitch timers
   // ------------------------------------------------------------
   logic [CNT_W-1:0] term_cnt_q, rechg_cnt_q, soc_cnt_q, bov_cnt_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         term_cnt_q <= '0;
         rechg_cnt_q <= '0;
         soc_cnt_q <= '0;
         bov_cnt_q <= '0;
         term_q <= 1'b0;
         rechg_q <= 1'b0;
         sysoc_q <= 1'b0;
         batov_q <= 1'b0;
      end else begin
         term_cnt_q  <= !term ? '0 : (term_q ? term_cnt_q : term_cnt_q + 1'b1);
         rechg_cnt_q <= !rechg ? '0 : (rechg_q ? rechg_cnt_q : rechg_cnt_q + 1'b1);
         soc_cnt_q   <= !sysoc ? '0 : (sysoc_q ? soc_cnt_q : soc_cnt_q + 1'b1);
         bov_cnt_q   <= !batov ? '0 : (batov_q ? bov_cnt_q : bov_cnt_q + 1'b1);
         term_q  <= term && (term_q || term_cnt_q == CNT_W'(P_TERM - 1));
         rechg_q <= rechg && (rechg_q || rechg_cnt_q == CNT_W'(P_TERM - 1));
         sysoc_q <= sysoc && (sysoc_q || soc_cnt_q == CNT_W'(C_SYSOVLD - 1));
         batov_q <= batov && (batov_q || bov_cnt_q == CNT_W'(C_BATOVP - 1));
      end
   end

   // ------------------------------------------------------------
   // charge safety and top-off timers
   // ------------------------------------------------------------
   logic [CNT_W-1:0] safe_cnt_q, top_cnt_q;
   logic charging;
   assign charging = converter_en && ctrl_q[B_CHG_EN] && !batov_q && !safety_expired
                     && !charge_done && battery_switch;
   always_ff @(posedge aclk) begin
      if (!aresetn || !converter_en || rechg_q) begin
         safe_cnt_q <= '0;
         top_cnt_q <= '0;
         safety_expired <= 1'b0;
         charge_done <= 1'b0;
      end else begin
         if (charging && ctrl_q[B_SAFE_SEL]) safe_cnt_q <= safe_cnt_q + 1'b1;
         if (safe_cnt_q == CNT_W'(P_SAFETY - 1)) safety_expired <= 1'b1;
         if (term_q && ctrl_q[B_TOP_HI:B_TOP_LO] == TOP_30M) top_cnt_q <= top_cnt_q + 1'b1;
         if (term_q && ctrl_q[B_TOP_HI:B_TOP_LO] != TOP_30M) charge_done <= 1'b1;
         if (top_cnt_q == CNT_W'(P_TOPOFF - 1)) charge_done <= 1'b1;
      end
   end
   assign charge_en = charging;

   // ------------------------------------------------------------
   // battery switch: ship mode, wake pin, full reset, overload
   // ------------------------------------------------------------
   wake_state_t wk_q;
   logic [CNT_W-1:0] wake_cnt_q, sm_cnt_q, rst_cnt_q;
   logic ship_pend_q, ship_q, rst_hold_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wk_q <= Q_IDLE;
         wake_cnt_q <= '0;
         sm_cnt_q <= '0;
         rst_cnt_q <= '0;
         ship_pend_q <= 1'b0;
         ship_q <= 1'b0;
         rst_hold_q <= 1'b0;
         battery_switch_disable_flag_q <= 1'b0;
      end else begin
         if (ship_req) ship_pend_q <= 1'b1;
         if (ship_pend_q) sm_cnt_q <= sm_cnt_q + 1'b1;
         if (ship_pend_q && sm_cnt_q == CNT_W'(P_SM_DLY - 1)) begin
            ship_q <= 1'b1;
            ship_pend_q <= 1'b0;
            sm_cnt_q <= '0;
         end
         case (wk_q)
            Q_IDLE: if (!wake_n) begin
               wk_q <= Q_LOW;
               wake_cnt_q <= '0;
            end
            Q_LOW: begin
               wake_cnt_q <= wake_cnt_q + 1'b1;
               if (wake_n) wk_q <= Q_IDLE;
               if (wake_cnt_q == CNT_W'(P_SHIP_EXIT - 1)) begin
                  ship_q <= 1'b0;
                  ship_pend_q <= 1'b0;
                  battery_switch_disable_flag_q <= 1'b0;
               end
               if (wake_cnt_q == CNT_W'(P_WAKE_RST - 1)) begin
                  rst_hold_q <= 1'b1;
                  rst_cnt_q <= '0;
                  wk_q <= Q_DONE;
               end
            end
            Q_DONE: if (wake_n) wk_q <= Q_IDLE;
            default: wk_q <= Q_IDLE;
         endcase
         if (sys_rst_req) begin
            rst_hold_q <= 1'b1;
            rst_cnt_q <= '0;
         end
         if (rst_hold_q) begin
            rst_cnt_q <= rst_cnt_q + 1'b1;
            if (rst_cnt_q == CNT_W'(P_BATRST - 1)) rst_hold_q <= 1'b0;
         end
         if (st_q == S_VLIM) battery_switch_disable_flag_q <= 1'b0;
         if (ovld || sysoc_q) battery_switch_disable_flag_q <= 1'b1;
      end
   end
   // battery alone above depletion keeps the switch closed
   assign battery_switch = (bdpl || converter_en) && !ship_q && !rst_hold_q
                           && !battery_switch_disable_flag_q && !ovld;

   // ------------------------------------------------------------
   // watchdog and digital clock selection
   // ------------------------------------------------------------
   logic [CNT_W-1:0] wd_cnt_q, div_cnt_q, div_lim;
   always_ff @(posedge aclk) begin
      if (!aresetn || wd_kick || !ctrl_q[B_WD_EN]) begin
         wd_cnt_q <= '0;
         wd_fault_q <= !aresetn ? 1'b1 : 1'b0;
      end else begin
         wd_fault_q <= 1'b0;
         wd_cnt_q <= wd_cnt_q + 1'b1;
         if (wd_cnt_q == CNT_W'(P_WDT - 1)) begin
            wd_fault_q <= 1'b1;
            wd_cnt_q <= '0;
         end
      end
   end
   assign div_lim = bias_regulator_en ? CNT_W'(C_DIV_FAST - 1) : CNT_W'(P_DIV_SLOW - 1);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_cnt_q <= '0;
         dig_clk_tick <= 1'b0;
      end else if (div_cnt_q >= div_lim) begin
         div_cnt_q <= '0;
         dig_clk_tick <= !dig_clk_tick;
      end else begin
         div_cnt_q <= div_cnt_q + 1'b1;
      end
   end
endmodule // charger_power_up_sequencer
`default_nettype wire

// ### tb/chg_seq_properties.sv
// Purpose: port checks for the power-up sequencer
// Assumes: bound onto the top module
// Notes:   window length follows the bound count
`timescale 1ns/100ps
`default_nettype none
module chg_seq_chk #(parameter longint P_BADSRC = 20) (
   input wire logic aclk, aresetn, input_present, input_overvoltage, bat_overload,
   input wire logic bat_overvoltage, bias_regulator_en, high_impedance_state, test_load_en,
   input wire logic converter_en, high_side_switch_en, battery_switch, charge_en, host_int_n
);
   longint tl_q;
   always_ff @(posedge aclk) tl_q <= (aresetn && test_load_en) ? tl_q + 1 : 0;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_HIGH_IMP: assert property (high_impedance_state == !bias_regulator_en)
      else $error("high impedance");
   AST_ORD: assert property (converter_en |-> bias_regulator_en) else $error("order");
   AST_OVP: assert property (input_overvoltage |-> !high_side_switch_en) else $error("ovp");
   AST_OFF: assert property (!input_present [*8] |-> !bias_regulator_en) else $error("off");
   AST_QUA: assert property ($rose(test_load_en) |-> bias_regulator_en) else $error("qual");
   AST_WIN: assert property ($fell(test_load_en) && bias_regulator_en |-> tl_q == P_BADSRC)
      else $error("window");
   AST_INT: assert property (!host_int_n |=> host_int_n) else $error("int");
   AST_DET: assert property ($rose(converter_en) |-> !$past(host_int_n) ||
      !$past(host_int_n, 2) || !$past(host_int_n, 3)) else $error("detect");
   AST_OVL: assert property (bat_overload [*6] |-> !battery_switch) else $error("ovl");
   AST_BOV: assert property (bat_overvoltage [*8] ##1 bat_overvoltage [*8]
      ##1 bat_overvoltage [*4] |-> !charge_en) else $error("bovp");
endmodule // chg_seq_chk
`default_nettype wire

// ### tb/src_model.sv
// Purpose: input source seen by the comparators
// Assumes: kind 0 absent, 1 strong, 2 weak
// Notes:   a weak source sags only under the test load
`timescale 1ns/100ps
`default_nettype none
module src_model (
   input wire logic       aclk,
   input wire logic       test_load_en,
   input wire logic [1:0] kind,
   output logic           input_present,
   output logic           input_above_bat,
   output logic           bus_above_min
);
   always_ff @(posedge aclk) begin
      input_present   <= kind != 2'h0;
      input_above_bat <= kind != 2'h0;
      bus_above_min   <= kind == 2'h1 || (kind == 2'h2 && !test_load_en);
   end
endmodule // src_model
`default_nettype wire

// ### tb/test_charger_power_up_sequencer.sv
// Purpose: self-checking bench for the power-up sequencer
// Assumes: counts shortened through parameters
// Notes:   register rows first, then sequences
`timescale 1ns/100ps
`default_nettype none
module test_charger_power_up_sequencer;
   import chg_seq_pkg::*;
   localparam logic [31:0] P_BADSRC = 32'h14, P_RETRY = 32'h64;
   typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [1:0] r;} row_t;
   logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, k, n;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, r, kind = 2'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic boost_mode = 1'h0, bus_below_bat = 1'h0, input_overvoltage = 1'h0, port_select = 1'h0;
   logic bat_above_depletion = 1'h1, term_cond = 1'h0, rechg_cond = 1'h0, sys_overcurrent = 1'h0;
   logic bat_overvoltage = 1'h0, bat_overload = 1'h0, ship_mode_wake_pin_n = 1'h1;
   logic input_present, input_above_bat, bus_above_min, bias_regulator_en, high_impedance_state;
   logic test_load_en, converter_en, high_side_switch_en, battery_switch, charge_en, host_int_n;
   logic dig_clk_tick;
   int miscompares = 0, n_compared = 0;
   row_t rows [8] = '{'{1'h0, 8'h00, CTRL_RST, 2'h0}, '{1'h0, 8'h08, {24'h0, ILIM_USB}, 2'h0},
      '{1'h0, 8'h0C, {24'h0, VLIM_RST}, 2'h0}, '{1'h0, 8'h10, 32'h0, 2'h2},
      '{1'h1, 8'h0C, 32'h33, 2'h0}, '{1'h0, 8'h0C, 32'h33, 2'h0},
      '{1'h1, 8'h10, 32'h1, 2'h2}, '{1'h1, 8'h00, CTRL_RST, 2'h0}};
   charger_power_up_sequencer #(.P_BIAS_DLY(50), .P_BADSRC(P_BADSRC), .P_RETRY(P_RETRY),
      .P_WDT(50000)) dut (.*, .safety_expired(), .charge_done());
   src_model src (.*);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk) begin s_axi_araddr <= a; s_axi_arvalid <= 1'h1; s_axi_rready <= 1'h1; end
      do @(negedge aclk); while (s_axi_arready !== 1'h1);
      @(posedge aclk) s_axi_arvalid <= 1'h0;
      do @(negedge aclk); while (s_axi_rvalid !== 1'h1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk) s_axi_rready <= 1'h0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic ta = 1'h0, tw = 1'h0;
      @(posedge aclk) begin s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_bready <= 1'h1; end
      @(posedge aclk) begin s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1; end
      while (!(ta && tw)) begin
         @(negedge aclk);
         ta |= s_axi_awready;
         tw |= s_axi_wready;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'h0;
         if (tw) s_axi_wvalid <= 1'h0;
      end
      do @(negedge aclk); while (s_axi_bvalid !== 1'h1);
      r = s_axi_bresp;
      @(posedge aclk) s_axi_bready <= 1'h0;
   endtask
   task automatic end_sim;
      if (miscompares == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial forever #50 aclk = ~aclk;
   initial begin
      repeat (6000) @(posedge aclk);
      miscompares++;
      end_sim;
   end
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (2) @(posedge aclk);
      foreach (rows[i]) begin
         if (rows[i].wr) wr(rows[i].a, rows[i].d);
         else rd(rows[i].a);
         chk(r, rows[i].r);
         if (!rows[i].wr) chk(d, rows[i].d);
      end
      chk(bias_regulator_en, 1'h0);
      chk(battery_switch, 1'h1);
      @(posedge aclk) kind <= 2'h2;
      for (k = 0; k < 400 && test_load_en !== 1'h1; k++) @(negedge aclk);
      for (k = 0; k < 400 && test_load_en !== 1'h0; k++) @(negedge aclk);
      chk(k, P_BADSRC);
      for (n = k; n < 400 && test_load_en !== 1'h1; n++) @(negedge aclk);
      chk(n, P_RETRY);
      chk(converter_en, 1'h0);
      @(posedge aclk) kind <= 2'h1;
      for (k = 0; k < 1000 && converter_en !== 1'h1; k++) @(negedge aclk);
      chk(converter_en, 1'h1);
      chk(high_impedance_state, 1'h0);
      rd(8'h04);
      chk(d[6:2], {2'h3, BUS_ADP});
      rd(8'h08);
      chk(d[7:0], ILIM_ADP);
      @(posedge dig_clk_tick);
      @(negedge aclk);
      for (k = 0; k < 400 && dig_clk_tick !== 1'h0; k++) @(negedge aclk);
      chk(k, 32'(C_DIV_FAST));
      chk(charge_en, 1'h1);
      @(posedge aclk) input_overvoltage <= 1'h1;
      @(negedge aclk) chk(high_side_switch_en, 1'h0);
      @(posedge aclk) begin input_overvoltage <= 1'h0; bat_overvoltage <= 1'h1; end
      repeat (25) @(negedge aclk);
      chk(charge_en, 1'h0);
      chk(battery_switch, 1'h1);
      @(posedge aclk) begin bat_overvoltage <= 1'h0; bat_overload <= 1'h1; end
      repeat (25) @(negedge aclk);
      chk(battery_switch, 1'h0);
      @(posedge aclk) bat_overload <= 1'h0;
      repeat (25) @(negedge aclk);
      chk(battery_switch, 1'h0);
      rd(8'h04);
      chk(d[7], 1'h1);
      @(posedge aclk) kind <= 2'h0;
      repeat (10) @(negedge aclk);
      chk(high_impedance_state, 1'h1);
      @(posedge dig_clk_tick);
      @(negedge aclk);
      for (k = 0; k < 400 && dig_clk_tick !== 1'h0; k++) @(negedge aclk);
      chk(k, 32'(C_DIV_SLOW));
      end_sim;
   end
endmodule // test_charger_power_up_sequencer
bind charger_power_up_sequencer chg_seq_chk #(.P_BADSRC(P_BADSRC)) chk (.*);
`default_nettype wire
